// [optmod_pkg.sv]
// Constants for the optical module control and status block.
// Assumes a 50 MHz core clock; all counts derive from that rate.
package optmod_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1_000;
  // Least time the disable pin must stay high to clear a fault
  localparam int unsigned T_FAULT_RST_US = 10;
  localparam int unsigned FAULT_RST_CYC = T_FAULT_RST_US * CLK_PER_US;
  // Longest time from power-on until the serial bus answers
  localparam int unsigned T_SERIAL_MS = 300;
  localparam int unsigned SERIAL_READY_CYC = T_SERIAL_MS * CLK_PER_MS;

  // ---------------------------------------------------------------
  // Two-wire addresses and register map
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_ID = 7'h50;
  localparam logic [6:0] ADDR_DIAG = 7'h51;
  localparam logic [7:0] REG_CTRL_STATUS = 8'h6e;
  localparam int unsigned BIT_HARD_OFF = 7;
  localparam int unsigned BIT_SOFT_OFF = 6;
  localparam int unsigned BIT_FAULT = 2;
  localparam int unsigned BIT_LOS = 1;
  localparam int unsigned BIT_DRDY = 0;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ---------------------------------------------------------------
  // Synchroniser reset values: scl and sda idle high
  // ---------------------------------------------------------------
  localparam logic [5:0] SYNC_RST = 6'h03;

  typedef enum logic [3:0] {
    IDLE, ADDR, ADDR_ACK, PTR, PTR_ACK, WDATA, WDATA_ACK, RDATA, RACK
  } bus_state_t;

endpackage : optmod_pkg

// [sync_2ff.sv]
// Two flip-flop synchroniser, one chain per bit.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ps
module sync_2ff #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ---------------------------------------------------------------
  // Per-bit chains
  // ---------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic stab_q;
    always_ff @(posedge core_clk) begin
      if (srst) begin
        meta_q <= RST_VAL[i];
        stab_q <= RST_VAL[i];
      end else begin
        meta_q <= d[i];
        stab_q <= meta_q;
      end
    end
    assign q[i] = stab_q;
  end
endmodule : sync_2ff

// [optical_module_ctrl_status.sv]
// Transmit/receive control and the control/status byte of an optical module,
// with the two-wire management slave that reaches it.
// Assumes all pins are asynchronous; power-on is seen as srst.
// Contract
// (RQ1) Hard disable rise turns light off fast
// (RQ2) Hard disable fall restores light within 1 ms
// (RQ3) Initialization, fault clear done within 300 ms
// (RQ4) Laser fault drives fault pin within 100 us
// (RQ5) Host holds disable 10 us to clear fault
// (RQ6) Signal loss raises loss pin within 100 us
// (RQ7) Signal return drops loss pin within 100 us
// (RQ8) Soft disable bit turns light off quickly
// (RQ9) Clearing soft disable restores light quickly
// (RQ10) Laser fault sets soft fault bit
// (RQ11) Soft loss bit follows optical signal
// (RQ12) Data ready bit reflects monitor health
// (RQ13) Bus answers only after 300 ms ready
// (RQ14) Writes complete at stop, within 10 ms
// (RQ15) Host keeps serial clock at most 100 kHz
// (RQ16) Either disable source keeps light off
`timescale 1ns/1ps
module optical_module_ctrl_status
  import optmod_pkg::*;
#(
  parameter int unsigned READY_CYC = SERIAL_READY_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic tx_off,
  input wire logic laser_fault,
  input wire logic signal_detect,
  input wire logic monitor_ok,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic laser_en,
  output logic tx_fault,
  output logic receive_signal_lost
);
  if (READY_CYC < 1 || READY_CYC >= (1 << 24)) begin : g_chk
    $error("READY_CYC out of range");
  end
  // ---------------------------------------------------------------
  // Pin synchronisers and bus edge detection
  // ---------------------------------------------------------------
  logic [5:0] sync_s;
  logic tx_off_s, fault_s, sig_s, mon_s, scl_s, sda_s;
  sync_2ff #(.W(6), .RST_VAL(SYNC_RST)) u_sync (.core_clk(core_clk), .srst(srst),
    .d({tx_off, laser_fault, signal_detect, monitor_ok, scl, sda_in}), .q(sync_s));
  assign {tx_off_s, fault_s, sig_s, mon_s, scl_s, sda_s} = sync_s;
  // A 100 kHz serial clock gives hundreds of core cycles per phase (see RQ15)
  logic scl_q, sda_q, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;
  // ---------------------------------------------------------------
  // Control and status state
  // ---------------------------------------------------------------
  logic fault_q, fault_d, soft_off_q, soft_off_d, los_q, los_d, drdy_q, drdy_d;
  logic laser_en_q, laser_en_d, tx_fault_q, tx_fault_d, ready_q, ready_d;
  logic [9:0] rst_cnt_q, rst_cnt_d;
  logic [23:0] rdy_cnt_q, rdy_cnt_d;
  logic [7:0] status;
  logic pend_q, pval_q;
  always_comb begin
    status = 8'h00;
    status[BIT_HARD_OFF] = tx_off_s;
    status[BIT_SOFT_OFF] = soft_off_q;
    status[BIT_FAULT] = fault_q;   // see RQ10
    status[BIT_LOS] = los_q;       // see RQ11
    status[BIT_DRDY] = drdy_q;
  end
  always_comb begin
    rst_cnt_d = rst_cnt_q;
    fault_d = fault_q;
    soft_off_d = soft_off_q;
    rdy_cnt_d = rdy_cnt_q;
    ready_d = ready_q;
    // Disable must stay high a full reset interval; counter saturates
    if (!tx_off_s) begin
      rst_cnt_d = 10'h000;
    end else if (rst_cnt_q != 10'(FAULT_RST_CYC)) begin
      rst_cnt_d = rst_cnt_q + 10'h001;
    end
    // Set wins over the clear by the disable pin
    if (fault_s) begin
      fault_d = 1'b1;                                   // see RQ4
    end else if (tx_off_s && rst_cnt_q == 10'(FAULT_RST_CYC - 1)) begin
      fault_d = 1'b0;                                   // see RQ5
    end
    // Staged write lands at the stop condition, far inside 10 ms
    if (stop_ev && pend_q) begin
      soft_off_d = pval_q;                              // see RQ14
    end
    if (!ready_q) begin
      rdy_cnt_d = rdy_cnt_q + 24'h000001;
      ready_d = (rdy_cnt_q == 24'(READY_CYC - 1));      // see RQ13
    end
    laser_en_d = !tx_off_s && !soft_off_q && !fault_q;  // see RQ1 RQ2 RQ3 RQ8 RQ9 RQ16
    tx_fault_d = fault_q;                               // see RQ4
    los_d = !sig_s;                                     // see RQ6 RQ7 RQ11
    drdy_d = mon_s;                                     // see RQ12
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rst_cnt_q <= 10'h000;
      fault_q <= 1'b0;
      soft_off_q <= 1'b0;
      rdy_cnt_q <= 24'h000000;
      ready_q <= 1'b0;
      laser_en_q <= 1'b0;
      tx_fault_q <= 1'b0;
      los_q <= 1'b1;
      drdy_q <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      rst_cnt_q <= rst_cnt_d;
      fault_q <= fault_d;
      soft_off_q <= soft_off_d;
      rdy_cnt_q <= rdy_cnt_d;
      ready_q <= ready_d;
      laser_en_q <= laser_en_d;
      tx_fault_q <= tx_fault_d;
      los_q <= los_d;
      drdy_q <= drdy_d;
    end
  end
  // ---------------------------------------------------------------
  // Two-wire slave
  // ---------------------------------------------------------------
  bus_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rd_byte;
  logic got8_q, got8_d, rw_q, rw_d, hi_q, hi_d, nack_q, nack_d;
  logic pend_d, pval_d, oe_q, oe_d, sda_out_q;
  // Only the control/status byte is mapped; all else reads zero
  assign rd_byte = (hi_q && ptr_q == REG_CTRL_STATUS) ? status : UNMAPPED_RD;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    got8_d = got8_q;
    rw_d = rw_q;
    hi_d = hi_q;
    nack_d = nack_q;
    pend_d = pend_q;
    pval_d = pval_q;
    oe_d = oe_q;
    if (stop_ev) begin
      st_d = IDLE;
      oe_d = 1'b0;
      pend_d = 1'b0;
    end else if (start_ev && ready_q) begin               // see RQ13
      st_d = ADDR;
      cnt_d = 3'h0;
      got8_d = 1'b0;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        ADDR, PTR, WDATA: begin
          sh_d = {sh_q[6:0], sda_s};
          cnt_d = cnt_q + 3'h1;
          got8_d = (cnt_q == 3'h7);
        end
        RACK: nack_d = sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        ADDR: if (got8_q) begin
          got8_d = 1'b0;
          if (sh_q[7:1] == ADDR_ID || sh_q[7:1] == ADDR_DIAG) begin
            oe_d = 1'b1;
            rw_d = sh_q[0];
            hi_d = (sh_q[7:1] == ADDR_DIAG);
            st_d = ADDR_ACK;
          end else begin
            st_d = IDLE;
          end
        end
        PTR: if (got8_q) begin
          got8_d = 1'b0;
          ptr_d = sh_q;
          oe_d = 1'b1;
          st_d = PTR_ACK;
        end
        WDATA: if (got8_q) begin
          got8_d = 1'b0;
          oe_d = 1'b1;
          ptr_d = ptr_q + 8'h01;
          st_d = WDATA_ACK;
          if (hi_q && ptr_q == REG_CTRL_STATUS) begin
            pend_d = 1'b1;                                // see RQ8 RQ14
            pval_d = sh_q[BIT_SOFT_OFF];
          end
        end
        PTR_ACK, WDATA_ACK: begin
          oe_d = 1'b0;
          st_d = WDATA;
        end
        RDATA: if (cnt_q == 3'h7) begin
          oe_d = 1'b0;
          st_d = RACK;
        end else begin
          sh_d = {sh_q[6:0], 1'b0};
          oe_d = ~sh_q[6];
          cnt_d = cnt_q + 3'h1;
        end
        ADDR_ACK, RACK: if (st_q == ADDR_ACK && !rw_q) begin
          oe_d = 1'b0;
          st_d = PTR;
        end else if (st_q == RACK && nack_q) begin
          oe_d = 1'b0;
          st_d = IDLE;
        end else begin
          sh_d = rd_byte;
          oe_d = ~rd_byte[7];
          ptr_d = ptr_q + 8'h01;
          cnt_d = 3'h0;
          st_d = RDATA;
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      got8_q <= 1'b0;
      rw_q <= 1'b0;
      hi_q <= 1'b0;
      nack_q <= 1'b0;
      pend_q <= 1'b0;
      pval_q <= 1'b0;
      oe_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      got8_q <= got8_d;
      rw_q <= rw_d;
      hi_q <= hi_d;
      nack_q <= nack_d;
      pend_q <= pend_d;
      pval_q <= pval_d;
      oe_q <= oe_d;
      sda_out_q <= 1'b0;
    end
  end
  assign sda_out = sda_out_q;
  assign sda_oe = oe_q;
  assign laser_en = laser_en_q;
  assign tx_fault = tx_fault_q;
  assign receive_signal_lost = los_q;
  // ---------------------------------------------------------------
  // Assertions and covers
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_hard_off: assert property (tx_off_s |=> !laser_en_q) // see RQ1
    else $error("light on while disable pin high");
  a_hard_on: assert property ($fell(tx_off_s) && !soft_off_q && !fault_q && !fault_s // see RQ2
    ##1 !tx_off_s && !soft_off_q && !fault_q |=> laser_en_q)
    else $error("light not restored after disable fall");
  a_fault_pin: assert property (fault_s |-> ##2 tx_fault_q) // see RQ4
    else $error("fault pin late");
  a_fault_clear: assert property (tx_off_s && !fault_s // see RQ5
    && rst_cnt_q == 10'(FAULT_RST_CYC - 1) |=> !fault_q)
    else $error("fault not cleared by disable hold");
  a_fault_hold: assert property (fault_q && rst_cnt_q < 10'(FAULT_RST_CYC - 1) |=> fault_q) // see RQ5
    else $error("fault cleared early");
  a_los_set: assert property (!sig_s [*2] |=> receive_signal_lost) // see RQ6
    else $error("loss pin not raised");
  a_los_clr: assert property (sig_s [*2] |=> !receive_signal_lost && !status[BIT_LOS]) // see RQ7
    else $error("loss pin not dropped");
  a_soft_commit: assert property (stop_ev && pend_q |=> soft_off_q == $past(pval_q)) // see RQ14
    else $error("soft write not committed at stop");
  a_soft_off: assert property (soft_off_q |=> !laser_en_q) // see RQ8
    else $error("light on with soft disable set");
  a_soft_fault: assert property (fault_s |=> status[BIT_FAULT]) // see RQ10
    else $error("soft fault bit missing");
  a_bus_quiet: assert property (!ready_q |-> !sda_oe && st_q == IDLE) // see RQ13
    else $error("bus answered before ready");
  c_soft_write: cover property (stop_ev && pend_q && pval_q);
  c_status_read: cover property (st_q == RDATA && hi_q && $past(ptr_q) == REG_CTRL_STATUS);
  c_fault_clear: cover property (fault_q ##1 !fault_q);
  c_hard_cycle: cover property ($fell(tx_off_s) ##[1:4] laser_en_q);
endmodule : optical_module_ctrl_status

// [i2c_host.sv]
// Host controller model for the two-wire management bus.
// Assumes the bench resolves sda as open drain with a pull-up.
`timescale 1ns/1ps
module i2c_host #(
  parameter int HALF = 250
) (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic host_oe
);
  // ---------------------------------------------
  // Bus phases
  // ---------------------------------------------
  // Half period of 250 cycles keeps scl at 100 kHz
  initial begin
    scl = 1'b1;
    host_oe = 1'b0;
  end
  task automatic q();
    repeat (HALF) @(negedge core_clk);
  endtask : q
  // Serves from idle and as a repeated start
  task automatic start();
    host_oe = 1'b0;
    q();
    scl = 1'b1;
    q();
    host_oe = 1'b1;
    q();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    host_oe = 1'b1;
    q();
    scl = 1'b1;
    q();
    host_oe = 1'b0;
    q();
  endtask : stop
  // Data changes only while scl is low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    host_oe = !b;
    q();
    scl = 1'b1;
    q();
    s = sda;
    scl = 1'b0;
  endtask : bit_io
  // Ninth bit is released, so the host never acknowledges a read byte
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : xfer
endmodule : i2c_host

// [tb.sv]
// Bench for the optical module control and status block.
// Assumes the host model of i2c_host.sv; sda has a pull-up.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("Error %0t: mismatch, got %h", $time, (a)); end end
module tb;
  import optmod_pkg::*;
  // Short ready time so an early access still lands before it
  localparam int unsigned RDY = 3000;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic tx_off = 1'b0;
  logic laser_fault = 1'b0;
  logic signal_detect = 1'b1;
  logic monitor_ok = 1'b1;
  logic scl, host_oe, sda_out, sda_oe, laser_en, tx_fault, receive_signal_lost;
  wire sda;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] rx;
  logic a0;
  assign sda = !(sda_oe | host_oe);
  optical_module_ctrl_status #(.READY_CYC(RDY)) DUT (.core_clk(core_clk), .srst(srst),
    .tx_off(tx_off), .laser_fault(laser_fault), .signal_detect(signal_detect),
    .monitor_ok(monitor_ok), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .laser_en(laser_en), .tx_fault(tx_fault),
    .receive_signal_lost(receive_signal_lost));
  i2c_host host (.core_clk(core_clk), .sda(sda), .scl(scl), .host_oe(host_oe));
  // ---------------------------------------------
  // Clock, timeout, tasks
  // ---------------------------------------------
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 95000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n
  task automatic wr(input logic [6:0] dev, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    host.start();
    host.xfer({dev, 1'b0}, r, k0);
    host.xfer(REG_CTRL_STATUS, r, k1);
    host.xfer(d, r, k2);
    host.stop();
    ok = k0 & k1 & k2;
  endtask : wr
  task automatic rd(output logic [7:0] d);
    logic [7:0] r;
    logic k;
    host.start();
    host.xfer({ADDR_DIAG, 1'b0}, r, k);
    host.xfer(REG_CTRL_STATUS, r, k);
    host.start();
    host.xfer({ADDR_DIAG, 1'b1}, r, k);
    host.xfer(8'hff, d, k);
    host.stop();
  endtask : rd
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial begin
    wait_n(10);
    `CHK(laser_en, 1'b0)
    `CHK(receive_signal_lost, 1'b1)
    srst = 1'b0;
    wait_n(5);
    `CHK(laser_en, 1'b1)
    `CHK(receive_signal_lost, 1'b0)
    wr(ADDR_DIAG, 8'h40, a0);
    `CHK(a0, 1'b0)
    `CHK(laser_en, 1'b1)
    $display("test reset done");
    tx_off = 1'b1;
    wait_n(5);
    `CHK(laser_en, 1'b0)
    tx_off = 1'b0;
    wait_n(5);
    `CHK(laser_en, 1'b1)
    signal_detect = 1'b0;
    wait_n(5);
    `CHK(receive_signal_lost, 1'b1)
    signal_detect = 1'b1;
    wait_n(5);
    `CHK(receive_signal_lost, 1'b0)
    $display("test pins done");
    laser_fault = 1'b1;
    wait_n(5);
    `CHK(tx_fault, 1'b1)
    `CHK(laser_en, 1'b0)
    laser_fault = 1'b0;
    tx_off = 1'b1;
    wait_n(100);
    tx_off = 1'b0;
    wait_n(10);
    `CHK(tx_fault, 1'b1)
    tx_off = 1'b1;
    wait_n(520);
    tx_off = 1'b0;
    wait_n(10);
    `CHK(tx_fault, 1'b0)
    `CHK(laser_en, 1'b1)
    $display("test fault done");
    wr(ADDR_DIAG, 8'h40, a0);
    `CHK(a0, 1'b1)
    wait_n(5);
    `CHK(laser_en, 1'b0)
    laser_fault = 1'b1;
    signal_detect = 1'b0;
    monitor_ok = 1'b0;
    wait_n(5);
    laser_fault = 1'b0;
    rd(rx);
    // Soft off, fault and loss set; monitor not ready
    `CHK(rx, 8'h46)
    signal_detect = 1'b1;
    monitor_ok = 1'b1;
    wr(ADDR_DIAG, 8'h00, a0);
    `CHK(a0, 1'b1)
    wait_n(5);
    // Latched fault must still hold the light off
    `CHK(laser_en, 1'b0)
    tx_off = 1'b1;
    wait_n(520);
    tx_off = 1'b0;
    wait_n(10);
    `CHK(laser_en, 1'b1)
    $display("test soft done");
    wr(ADDR_ID, 8'h40, a0);
    `CHK(a0, 1'b1)
    wait_n(5);
    // The control byte sits only behind the diagnostic address
    `CHK(laser_en, 1'b1)
    host.start();
    host.xfer({7'h52, 1'b0}, rx, a0);
    host.stop();
    `CHK(a0, 1'b0)
    `CHK(sda_out, 1'b0)
    $display("test address done");
    report_and_stop();
  end
endmodule : tb
